/* File: logic/diff_counter_pkg.sv */
//------------------------------------------------------------
// constants and carriers
//------------------------------------------------------------
package diff_counter_pkg;
  localparam int COUNT_W = 8;
  localparam int DIV_W = 17;
  localparam logic [7:0] OFFSET_FULL = 8'hFF;
  localparam logic [7:0] COUNT_CLEAR = 8'h00;
  localparam logic [16:0] DIV_ONE = 17'h00001;
  localparam logic [3:0] DECADE_LAST = 4'h9;
  localparam logic [3:0] DECADE_ZERO = 4'h0;
  // least spacing of two difference pulses, in ns
  localparam int REARM_NS = 200;
  localparam int CLK_NS = 4;
  localparam int REARM_CYC = (REARM_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] REARM_CNT = 8'(REARM_CYC);
  localparam logic [7:0] REARM_ZERO = 8'h00;

  typedef struct packed {
    logic gate_open;
    logic window_end;
    logic div_out;
  } gate_status_t;
endpackage

/* File: logic/diff_edge_former.sv */
`timescale 1ns/1ps
module diff_edge_former (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // synchronised square waves
  input wire logic i_ref_sq,
  input wire logic i_sig_sq,
  // output
  output logic o_diff_pulse,
  output logic o_ref_rise
);
  logic ref_d_reg, ref_d_next;
  logic sig_d_reg, sig_d_next;
  logic held_reg, held_next;
  logic pulse_reg, pulse_next;
  logic [7:0] rearm_reg, rearm_next;
  logic ref_rise, sig_rise;

  always_comb begin
    ref_d_next = i_ref_sq;
    sig_d_next = i_sig_sq;
    ref_rise = i_ref_sq && !ref_d_reg;
    sig_rise = i_sig_sq && !sig_d_reg;
    held_next = held_reg;
    pulse_next = 1'b0;
    rearm_next = rearm_reg;
    if (rearm_reg != diff_counter_pkg::REARM_ZERO) begin
      rearm_next = rearm_reg - 8'h01;
    end
    // one edge of each train cancels; an unmatched run yields a pulse
    if (ref_rise && !sig_rise) begin
      if (held_reg && rearm_reg == diff_counter_pkg::REARM_ZERO) begin
        pulse_next = 1'b1;
        held_next = 1'b0;
        rearm_next = diff_counter_pkg::REARM_CNT;
      end else begin
        held_next = 1'b1;
      end
    end else if (sig_rise && !ref_rise) begin
      held_next = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_d_reg <= 1'b0;
      sig_d_reg <= 1'b0;
      held_reg <= 1'b0;
      pulse_reg <= 1'b0;
      rearm_reg <= diff_counter_pkg::REARM_ZERO;
    end else begin
      ref_d_reg <= ref_d_next;
      sig_d_reg <= sig_d_next;
      held_reg <= held_next;
      pulse_reg <= pulse_next;
      rearm_reg <= rearm_next;
    end
  end

  assign o_diff_pulse = pulse_reg;
  assign o_ref_rise = ref_rise;
endmodule

/* File: logic/gated_difference_pulse_counter.sv */
`timescale 1ns/1ps
module gated_difference_pulse_counter #(
  parameter int DIV_W = diff_counter_pkg::DIV_W,
  parameter int COUNT_W = diff_counter_pkg::COUNT_W
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // comparator outputs from the transducers
  input wire logic i_ref_comp,
  input wire logic i_sig_comp,
  // installer switches
  input wire logic [DIV_W-1:0] i_div_ratio,
  input wire logic [COUNT_W-1:0] i_offset_preset,
  // converter side
  output logic [COUNT_W-1:0] o_dac_word,
  output diff_counter_pkg::gate_status_t o_status
);
  //------------------------------------------------------------
  // input synchronisers and schmitt filtering
  //------------------------------------------------------------
  logic ref_s1_reg, ref_s2_reg, sig_s1_reg, sig_s2_reg;
  logic ref_hist_reg, sig_hist_reg, ref_sq_reg, sig_sq_reg;
  logic ref_sq_next, sig_sq_next;

  // hysteresis: two agreeing samples are needed to flip the square wave
  always_comb begin
    ref_sq_next = ref_sq_reg;
    sig_sq_next = sig_sq_reg;
    if (ref_s2_reg == ref_hist_reg) begin
      ref_sq_next = ref_s2_reg;
    end
    if (sig_s2_reg == sig_hist_reg) begin
      sig_sq_next = sig_s2_reg;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
      sig_s1_reg <= 1'b0;
      sig_s2_reg <= 1'b0;
      ref_hist_reg <= 1'b0;
      sig_hist_reg <= 1'b0;
      ref_sq_reg <= 1'b0;
      sig_sq_reg <= 1'b0;
    end else begin
      ref_s1_reg <= i_ref_comp;
      ref_s2_reg <= ref_s1_reg;
      sig_s1_reg <= i_sig_comp;
      sig_s2_reg <= sig_s1_reg;
      ref_hist_reg <= ref_s2_reg;
      sig_hist_reg <= sig_s2_reg;
      ref_sq_reg <= ref_sq_next;
      sig_sq_reg <= sig_sq_next;
    end
  end

  logic diff_pulse, ref_rise;

  diff_edge_former u_former (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ref_sq(ref_sq_reg),
    .i_sig_sq(sig_sq_reg),
    .o_diff_pulse(diff_pulse),
    .o_ref_rise(ref_rise)
  );

  //------------------------------------------------------------
  // divide by M and divide by ten
  //------------------------------------------------------------
  // the decade stage toggles every 10*M reference edges (ten divide-by-M ticks), so the
  // gate control is a true square wave whatever M is
  logic [DIV_W-1:0] div_cnt_reg, div_cnt_next;
  logic div_out_reg, div_out_next;
  logic [3:0] decade_reg, decade_next;
  logic decade_out_reg, decade_out_next;
  logic div_tick;

  always_comb begin
    div_cnt_next = div_cnt_reg;
    div_out_next = div_out_reg;
    decade_next = decade_reg;
    decade_out_next = decade_out_reg;
    div_tick = 1'b0;
    if (ref_rise) begin
      if (div_cnt_reg + DIV_W'(diff_counter_pkg::DIV_ONE) >= i_div_ratio) begin
        div_cnt_next = '0;
        div_tick = 1'b1;
      end else begin
        div_cnt_next = div_cnt_reg + DIV_W'(diff_counter_pkg::DIV_ONE);
      end
    end
    if (div_tick) begin
      if (decade_reg == diff_counter_pkg::DECADE_LAST) begin
        decade_next = diff_counter_pkg::DECADE_ZERO;
        decade_out_next = !decade_out_reg;
      end else begin
        decade_next = decade_reg + 4'h1;
      end
    end
    div_out_next = decade_out_next;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_reg <= '0;
      div_out_reg <= 1'b0;
      decade_reg <= diff_counter_pkg::DECADE_ZERO;
      decade_out_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      div_out_reg <= div_out_next;
      decade_reg <= decade_next;
      decade_out_reg <= decade_out_next;
    end
  end

  // falling edge of gate control ends the window; rising starts the next
  logic window_end, window_start;
  assign window_end = div_out_reg && !div_out_next;
  assign window_start = !div_out_reg && div_out_next;

  //------------------------------------------------------------
  // zero offset counter, gate, pulse counter and latches
  //------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_OPEN} gate_state_t;
  gate_state_t state_reg, state_next;
  logic [COUNT_W-1:0] offset_reg, offset_next;
  logic [COUNT_W-1:0] count_reg, count_next;
  logic [COUNT_W-1:0] latch_reg, latch_next;
  logic offset_done, gate_open;
  logic end_reg, end_next;

  assign offset_done = offset_reg == COUNT_W'(diff_counter_pkg::OFFSET_FULL);
  // gate needs control high and offset finished; it opens in the same cycle the
  // offset count completes, so the pulse that starts a window is not lost
  assign gate_open = div_out_reg && offset_done && state_reg != ST_IDLE;

  always_comb begin
    state_next = state_reg;
    offset_next = offset_reg;
    count_next = count_reg;
    latch_next = latch_reg;
    end_next = window_end;
    unique case (state_reg)
      ST_IDLE: begin
        if (window_start) begin
          offset_next = i_offset_preset;
          count_next = COUNT_W'(diff_counter_pkg::COUNT_CLEAR);
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (window_end) begin
          state_next = ST_IDLE;
        end else if (offset_done) begin
          state_next = ST_OPEN;
          if (diff_pulse && gate_open) begin
            count_next = count_reg + COUNT_W'(1);
          end
        end else if (diff_pulse) begin
          offset_next = offset_reg + COUNT_W'(1);
        end
      end
      ST_OPEN: begin
        if (window_end) begin
          state_next = ST_IDLE;
        end else if (diff_pulse && gate_open) begin
          count_next = count_reg + COUNT_W'(1);
        end
      end
    endcase
    // capture at every window end; held while the gate is shut
    if (window_end) begin
      latch_next = count_reg;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      offset_reg <= COUNT_W'(diff_counter_pkg::COUNT_CLEAR);
      count_reg <= COUNT_W'(diff_counter_pkg::COUNT_CLEAR);
      latch_reg <= COUNT_W'(diff_counter_pkg::COUNT_CLEAR);
      end_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      offset_reg <= offset_next;
      count_reg <= count_next;
      latch_reg <= latch_next;
      end_reg <= end_next;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  logic gate_reg;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      gate_reg <= 1'b0;
    end else begin
      gate_reg <= gate_open;
    end
  end

  // a window ends every 20*M reference edges, well under 2.5 s for legal M
  assign o_dac_word = latch_reg;
  assign o_status.gate_open = gate_reg;
  assign o_status.window_end = end_reg;
  assign o_status.div_out = div_out_reg;
endmodule

/* File: verification/diff_counter_assertions.sv */
`timescale 1ns/1ps
module diff_counter_assertions #(
  parameter int DIV_W = diff_counter_pkg::DIV_W,
  parameter int COUNT_W = diff_counter_pkg::COUNT_W
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // watched ports
  input wire logic i_ref_comp,
  input wire logic i_sig_comp,
  input wire logic [DIV_W-1:0] i_div_ratio,
  input wire logic [COUNT_W-1:0] i_offset_preset,
  input wire logic [COUNT_W-1:0] o_dac_word,
  input wire diff_counter_pkg::gate_status_t o_status
);
  //------------------------------------------------------------
  // reference edges seen since the last divider toggle
  //------------------------------------------------------------
  logic ref_reg, ref_next, div_reg, div_next;
  int edges_reg, edges_next, half_edges;
  // a ratio of zero divides by one, as the switch reading allows
  assign half_edges = 10 * ((i_div_ratio == '0) ? 1 : int'(i_div_ratio));
  always_comb begin
    ref_next = i_ref_comp;
    div_next = o_status.div_out;
    edges_next = (div_next != div_reg) ? 0 : edges_reg;
    if (i_ref_comp && !ref_reg) edges_next = edges_next + 1;
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_reg <= 1'b0;
      div_reg <= 1'b0;
      edges_reg <= 0;
    end else begin
      ref_reg <= ref_next;
      div_reg <= div_next;
      edges_reg <= edges_next;
    end
  end
  //------------------------------------------------------------
  // properties
  //------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_DIV_HALF: assert property ($changed(o_status.div_out) |-> edges_reg == half_edges)
    else $error("divider toggled after wrong edge count");
  AST_DIV_STEADY: assert property ($changed(o_status.div_out) |=> $stable(o_status.div_out)[*8])
    else $error("divider output toggled too soon");
  AST_GATE_IN_HIGH: assert property (o_status.gate_open |-> (o_status.div_out || $past(o_status.div_out)))
    else $error("gate open while divider low");
  AST_GATE_SHUT: assert property ($fell(o_status.div_out) |-> ##2 (!o_status.gate_open)[*4])
    else $error("gate still open after divider fell");
  AST_WORD_HELD: assert property (!o_status.window_end |-> $stable(o_dac_word))
    else $error("word changed outside window end");
  AST_END_PULSE: assert property (o_status.window_end |=> !o_status.window_end)
    else $error("window end longer than one cycle");
  AST_END_ON_FALL: assert property ($fell(o_status.div_out) |-> ##[0:3] o_status.window_end)
    else $error("no window end after divider fell");
  AST_HOLD_GATE: assert property ($rose(o_status.div_out) && i_offset_preset != 8'hFF
    |-> (!o_status.gate_open)[*2])
    else $error("gate opened before offset count done");
  AST_FULL_OPENS: assert property ($rose(o_status.div_out) && i_offset_preset == 8'hFF
    |-> ##[1:3] o_status.gate_open)
    else $error("full preset did not open gate");
  cover property (o_status.window_end && o_dac_word != 8'h00);
  cover property (o_status.window_end && o_dac_word == 8'h00);
  cover property ($rose(o_status.gate_open));
endmodule

bind gated_difference_pulse_counter diff_counter_assertions #(.DIV_W(DIV_W), .COUNT_W(COUNT_W)) chk_u (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ref_comp(i_ref_comp), .i_sig_comp(i_sig_comp),
  .i_div_ratio(i_div_ratio), .i_offset_preset(i_offset_preset), .o_dac_word(o_dac_word), .o_status(o_status));

/* File: verification/transducer_model.sv */
`timescale 1ns/1ps
module transducer_model #(
  parameter int HALF = 20
) (
  // clock
  input wire logic i_sys_clk,
  // controls
  input wire logic i_run,
  input wire logic i_sig_on,
  // comparator levels
  output logic o_ref_comp = 1'b0,
  output logic o_sig_comp = 1'b0
);
  //------------------------------------------------------------
  // squared oscillator outputs
  //------------------------------------------------------------
  int phase_reg = 0;
  // signal runs at the reference rate a quarter period late, so edges alternate
  always @(posedge i_sys_clk) begin
    phase_reg <= (i_run && phase_reg < 2 * HALF - 1) ? phase_reg + 1 : 0;
    o_ref_comp <= i_run && phase_reg < HALF;
    o_sig_comp <= i_run && i_sig_on && phase_reg >= HALF / 2 && phase_reg < HALF + HALF / 2;
  end
endmodule

/* File: verification/gated_difference_pulse_counter_test.sv */
`timescale 1ns/1ps
module gated_difference_pulse_counter_test;
  localparam int REF_PER = 40;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic run = 1'b0;
  logic sig_on = 1'b0;
  logic ref_comp, sig_comp;
  logic [16:0] div_ratio = 17'h00001;
  logic [7:0] offset_preset = 8'hFF;
  logic [7:0] dac_word;
  diff_counter_pkg::gate_status_t status;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #2 i_sys_clk = ~i_sys_clk;

  transducer_model #(.HALF(REF_PER / 2)) far_u (.i_sys_clk(i_sys_clk), .i_run(run), .i_sig_on(sig_on),
    .o_ref_comp(ref_comp), .o_sig_comp(sig_comp));
  gated_difference_pulse_counter dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ref_comp(ref_comp),
    .i_sig_comp(sig_comp), .i_div_ratio(div_ratio), .i_offset_preset(offset_preset),
    .o_dac_word(dac_word), .o_status(status));

  //------------------------------------------------------------
  // shared tasks
  //------------------------------------------------------------
  task automatic wrap_up();
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      $display("[FAIL] %0t run too long", $time);
      wrap_up();
    end
  end

  task automatic check_word(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t value %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_cyc(input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      n_errors++;
      $display("[FAIL] %0t span %0d expected %0d", $time, got, exp);
    end
  endtask

  // switches only change while reset holds the block
  task automatic start(input logic [16:0] m, input logic [7:0] z, input logic s);
    i_rst <= 1'b1;
    run <= 1'b0;
    div_ratio <= m;
    offset_preset <= z;
    sig_on <= s;
    repeat (5) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    run <= 1'b1;
  endtask

  task automatic wait_end();
    @(posedge i_sys_clk);
    while (status.window_end !== 1'b1) @(posedge i_sys_clk);
  endtask

  // second window judged, so the first settles any start-up phase
  task automatic run_case(input logic [16:0] m, input logic [7:0] z, input logic s, input logic [7:0] exp);
    start(m, z, s);
    wait_end();
    wait_end();
    check_word(exp, dac_word);
  endtask

  //------------------------------------------------------------
  // scenarios
  //------------------------------------------------------------
  task automatic t_reset();
    start(17'h00001, 8'hFF, 1'b0);
    repeat (300) @(posedge i_sys_clk);
    check_word(8'h00, dac_word);
    check_word(8'h00, {5'h00, status});
  endtask

  task automatic t_plain();
    int t0;
    start(17'h00001, 8'hFF, 1'b0);
    wait_end();
    check_word(8'h05, dac_word);
    t0 = cycles;
    wait_end();
    check_cyc(20 * REF_PER, cycles - t0);
    check_word(8'h05, dac_word);
    while (status.div_out !== 1'b1) @(posedge i_sys_clk);
    t0 = cycles;
    while (status.div_out === 1'b1) @(posedge i_sys_clk);
    check_cyc(10 * REF_PER, cycles - t0);
  endtask

  task automatic t_ratio();
    run_case(17'h00002, 8'hFF, 1'b0, 8'h0A);
  endtask

  task automatic t_zero_m();
    run_case(17'h00000, 8'hFF, 1'b0, 8'h05);
  endtask

  task automatic t_offset();
    run_case(17'h00002, 8'hFD, 1'b0, 8'h08);
  endtask

  task automatic t_match();
    run_case(17'h00001, 8'hFF, 1'b1, 8'h00);
  endtask

  initial begin
    t_reset();
    t_plain();
    t_ratio();
    t_zero_m();
    t_offset();
    t_match();
    wrap_up();
  end
endmodule
